/* logic/serial_link_cfg_pkg.sv */
// constants shared by the serial link configuration register bank
package serial_link_cfg_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam int         NUM_REGS        = 5;
   localparam int         IDX_TAG_0       = 0;
   localparam int         IDX_TAG_1       = 1;
   localparam int         IDX_SERIAL_CFG  = 2;
   localparam int         IDX_PART_IDENT  = 3;
   localparam int         IDX_CLIENT_ADDR = 4;
   localparam logic [7:0] OFF_TAG_0       = 8'h1A;
   localparam logic [7:0] OFF_TAG_1       = 8'h1B;
   localparam logic [7:0] OFF_SERIAL_CFG  = 8'h3D;
   localparam logic [7:0] OFF_PART_IDENT  = 8'h3E;
   localparam logic [7:0] OFF_CLIENT_ADDR = 8'h3F;
   localparam logic [7:0] REG_OFFSET [0:NUM_REGS-1] =
      '{OFF_TAG_0, OFF_TAG_1, OFF_SERIAL_CFG, OFF_PART_IDENT, OFF_CLIENT_ADDR};

   // ---------------------------------------------------------------
   // reset values and read substitutes
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_RESET           = 8'h00;
   localparam logic [7:0] UNMAPPED_READ       = 8'h00;
   localparam logic [7:0] EMPTY_VALUE         = 8'h00;
   localparam logic [7:0] CLIENT_ADDR_DEFAULT = 8'h60;

   // ---------------------------------------------------------------
   // field layout
   // ---------------------------------------------------------------
   localparam int TAG_ENABLE_BIT = 7;
   localparam int TAG_ID_MSB     = 3;
   localparam int TAG_ID_LSB     = 0;
   localparam int WIDTH_SEL_BIT  = 6;
   localparam int CHK_LEN_MSB    = 5;
   localparam int CHK_LEN_LSB    = 4;
   localparam int SEED_MSB       = 3;
   localparam int SEED_LSB       = 0;
   localparam int CLIENT_MSB     = 6;

   // ---------------------------------------------------------------
   // check length codes, polynomials (leading term dropped), seeds
   // ---------------------------------------------------------------
   localparam logic [1:0] LEN_SEL_8       = 2'h0;
   localparam logic [1:0] LEN_SEL_4       = 2'h1;
   localparam logic [1:0] LEN_SEL_3       = 2'h2;
   localparam logic [7:0] POLY_8          = 8'h2F;
   localparam logic [7:0] POLY_4          = 8'h01;
   localparam logic [7:0] POLY_3          = 8'h03;
   localparam logic [7:0] SEED_DEFAULT_8  = 8'hFF;
   localparam logic [7:0] SEED_DEFAULT_4  = 8'h0A;
   localparam logic [7:0] SEED_DEFAULT_3  = 8'h07;
   localparam logic [3:0] SEED_ZERO       = 4'h0;
   localparam logic [7:0] SEED_MASK_8     = 8'h0F;
   localparam logic [7:0] SEED_MASK_4     = 8'h0F;
   localparam logic [7:0] SEED_MASK_3     = 8'h07;

endpackage

/* logic/serial_link_config_regs.sv */
// serial link configuration register bank with link-clock access port
//
// Operation
// - In SPI mode an enabled source channel carries its sensor result and a disabled one the error response.
// - The error response can be put on either source channel by clearing that channel's enable.
// - In I2C mode the two source enables set the read address wrap-around of multi-byte reads.
// - In I2C mode the source tag registers still read and write but steer nothing except wrap-around.
// - Bit 6 of the serial configuration selects a 12-bit data field at 0 and 16-bit at 1.
// - The length field selects 8-bit, 4-bit or (for both upper codes) 3-bit check with its polynomial.
// - A zero seed field gives the default seed FFh, 1010 or 111 for the chosen length.
// - A non-zero seed field is used as the seed, zero-extended, whole, or low three bits.
// - New polynomial or seed take effect on both directions from the next command onward.
// - The identification register resets to 00h and then reads as a fixed code, else its value.
// - A zero client address register gives client address 60h and reads as 60h.
// - A non-zero client address register gives its low seven bits as address and reads whole.
// - Stored configuration, identification and client address values are checked for corruption.
// - The serial configuration register can be read and written in either interface mode.
// - The client address register can be read in every interface mode.
// - Source tags at 1Ah and 1Bh hold enable in bit 7 and identifier in bits 3..0, reset to zero.
`timescale 1ns/1ns
`default_nettype none

module serial_link_config_regs #(
   parameter logic [7:0] PART_IDENT_CODE = 8'hA5  // arbitrary neutral identifier value
) (
   // system clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   // link-side register access (link_clk domain)
   input  wire logic       link_clk,
   input  wire logic       link_req,
   input  wire logic       link_wr,
   input  wire logic [7:0] link_addr,
   input  wire logic [7:0] link_wdata,
   input  wire logic       link_cmd_start,
   output var  logic [7:0] link_rdata_reg,
   output var  logic       link_done_reg,
   output var  logic       link_busy_reg,
   // interface mode pin (asynchronous)
   input  wire logic       i2c_mode,
   // source channel steering
   output var  logic [1:0] result_sel_reg,
   output var  logic [1:0] wrap_en_reg,
   output var  logic [3:0] source_tag_0_reg,
   output var  logic [3:0] source_tag_1_reg,
   // frame and check configuration
   output var  logic       field_width_16_reg,
   output var  logic [1:0] check_len_sel_reg,
   output var  logic [7:0] check_poly_reg,
   output var  logic [7:0] check_seed_reg,
   // client address and array integrity
   output var  logic [6:0] client_addr_reg,
   output var  logic       array_fault_reg
);

   // ---------------------------------------------------------------
   // link domain: request capture and toggles
   // ---------------------------------------------------------------
   logic       req_tgl_reg;
   logic       cmd_tgl_reg;
   logic       hold_wr_reg;
   logic [7:0] hold_addr_reg;
   logic [7:0] hold_wdata_reg;
   logic       ack_prev_reg;
   logic       ack_sync;
   logic [7:0] sys_rdata_reg;
   logic       sys_ack_tgl_reg;
   wire        link_accept = link_req & ~link_busy_reg;
   wire        ack_event   = ack_sync ^ ack_prev_reg;

   // hold address and data stable while the request is in flight
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_tgl_reg    <= 1'b0;
         hold_wr_reg    <= 1'b0;
         hold_addr_reg  <= serial_link_cfg_pkg::REG_RESET;
         hold_wdata_reg <= serial_link_cfg_pkg::REG_RESET;
      end else if (link_accept) begin
         req_tgl_reg    <= ~req_tgl_reg;
         hold_wr_reg    <= link_wr;
         hold_addr_reg  <= link_addr;
         hold_wdata_reg <= link_wdata;
      end
   end

   // command boundary event toward the system domain
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_tgl_reg <= 1'b0;
      end else if (link_cmd_start) begin
         cmd_tgl_reg <= ~cmd_tgl_reg;
      end
   end

   // busy until the answer returns, then one-cycle done
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         link_busy_reg  <= 1'b0;
         link_done_reg  <= 1'b0;
         ack_prev_reg   <= 1'b0;
         link_rdata_reg <= serial_link_cfg_pkg::REG_RESET;
      end else begin
         ack_prev_reg  <= ack_sync;
         link_done_reg <= ack_event;
         if (ack_event) begin
            link_busy_reg  <= 1'b0;
            link_rdata_reg <= sys_rdata_reg;
         end else if (link_accept) begin
            link_busy_reg <= 1'b1;
         end
      end
   end

   sync_two_ff #(.WIDTH(1)) u_ack_sync (
      .clk      (link_clk),
      .reset_n  (reset_n),
      .async_in (sys_ack_tgl_reg),
      .sync_out (ack_sync)
   );

   // ---------------------------------------------------------------
   // system domain: synchronised events and mode
   // ---------------------------------------------------------------
   logic req_sync;
   logic cmd_sync;
   logic mode_i2c_sync;
   logic req_prev_reg;
   logic cmd_prev_reg;
   wire  req_event = req_sync ^ req_prev_reg;
   wire  cmd_event = cmd_sync ^ cmd_prev_reg;

   sync_two_ff #(.WIDTH(3)) u_sys_sync (
      .clk      (sys_clk),
      .reset_n  (reset_n),
      .async_in ({req_tgl_reg, cmd_tgl_reg, i2c_mode}),
      .sync_out ({req_sync, cmd_sync, mode_i2c_sync})
   );

   // edge memory for the toggles
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_prev_reg <= 1'b0;
         cmd_prev_reg <= 1'b0;
      end else begin
         req_prev_reg <= req_sync;
         cmd_prev_reg <= cmd_sync;
      end
   end

   // ---------------------------------------------------------------
   // register array with per-register parity
   // ---------------------------------------------------------------
   logic [7:0]                               stored_reg [0:serial_link_cfg_pkg::NUM_REGS-1];
   logic [serial_link_cfg_pkg::NUM_REGS-1:0] parity_reg;
   logic [serial_link_cfg_pkg::NUM_REGS-1:0] wr_hit;
   logic [serial_link_cfg_pkg::NUM_REGS-1:0] parity_bad;

   // every register writable in both modes, no mode gating
   genvar gi;
   generate
      for (gi = 0; gi < serial_link_cfg_pkg::NUM_REGS; gi++) begin : g_reg
         assign wr_hit[gi] = req_event & hold_wr_reg
                           & (hold_addr_reg == serial_link_cfg_pkg::REG_OFFSET[gi]);
         assign parity_bad[gi] = ^{stored_reg[gi], parity_reg[gi]};

         // all registers reset to 00h
         always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               stored_reg[gi] <= serial_link_cfg_pkg::REG_RESET;
               parity_reg[gi] <= 1'b0;
            end else if (wr_hit[gi]) begin
               stored_reg[gi] <= hold_wdata_reg;
               parity_reg[gi] <= ^hold_wdata_reg;
            end
         end
      end
   endgenerate

   // sticky flag on any parity mismatch
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         array_fault_reg <= 1'b0;
      end else if (|parity_bad) begin
         array_fault_reg <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // read path with substitutes
   // ---------------------------------------------------------------
   wire [7:0] tag_0_val   = stored_reg[serial_link_cfg_pkg::IDX_TAG_0];
   wire [7:0] tag_1_val   = stored_reg[serial_link_cfg_pkg::IDX_TAG_1];
   wire [7:0] cfg_val     = stored_reg[serial_link_cfg_pkg::IDX_SERIAL_CFG];
   wire [7:0] ident_val   = stored_reg[serial_link_cfg_pkg::IDX_PART_IDENT];
   wire [7:0] client_val  = stored_reg[serial_link_cfg_pkg::IDX_CLIENT_ADDR];
   wire       ident_empty = (ident_val == serial_link_cfg_pkg::EMPTY_VALUE);
   wire       client_empty = (client_val == serial_link_cfg_pkg::EMPTY_VALUE);
   // substitution on reads and the client address output, storage untouched
   wire [7:0] ident_read  = ident_empty ? PART_IDENT_CODE : ident_val;
   wire [7:0] client_read = client_empty ? serial_link_cfg_pkg::CLIENT_ADDR_DEFAULT
                                         : client_val;
   wire [7:0] rd_value =
      (hold_addr_reg == serial_link_cfg_pkg::OFF_TAG_0)       ? tag_0_val   :
      (hold_addr_reg == serial_link_cfg_pkg::OFF_TAG_1)       ? tag_1_val   :
      (hold_addr_reg == serial_link_cfg_pkg::OFF_SERIAL_CFG)  ? cfg_val     :
      (hold_addr_reg == serial_link_cfg_pkg::OFF_PART_IDENT)  ? ident_read  :
      (hold_addr_reg == serial_link_cfg_pkg::OFF_CLIENT_ADDR) ? client_read :
                                                                serial_link_cfg_pkg::UNMAPPED_READ;

   // answer every request once, read data taken before any write
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sys_rdata_reg   <= serial_link_cfg_pkg::REG_RESET;
         sys_ack_tgl_reg <= 1'b0;
      end else if (req_event) begin
         sys_rdata_reg   <= rd_value;
         sys_ack_tgl_reg <= ~sys_ack_tgl_reg;
      end
   end

   // ---------------------------------------------------------------
   // check configuration decode
   // ---------------------------------------------------------------
   function automatic logic [1:0] len_code(input logic [1:0] field);
      // both upper codes give the 3-bit check
      case (field)
         2'h0:    len_code = serial_link_cfg_pkg::LEN_SEL_8;
         2'h1:    len_code = serial_link_cfg_pkg::LEN_SEL_4;
         default: len_code = serial_link_cfg_pkg::LEN_SEL_3;
      endcase
   endfunction

   wire [1:0] cfg_len   = cfg_val[serial_link_cfg_pkg::CHK_LEN_MSB:serial_link_cfg_pkg::CHK_LEN_LSB];
   wire [3:0] cfg_seed  = cfg_val[serial_link_cfg_pkg::SEED_MSB:serial_link_cfg_pkg::SEED_LSB];
   wire [1:0] len_next  = len_code(cfg_len);
   wire       seed_zero = (cfg_seed == serial_link_cfg_pkg::SEED_ZERO);
   wire [7:0] seed_wide = {4'h0, cfg_seed};
   wire [7:0] poly_next =
      (len_next == serial_link_cfg_pkg::LEN_SEL_8) ? serial_link_cfg_pkg::POLY_8 :
      (len_next == serial_link_cfg_pkg::LEN_SEL_4) ? serial_link_cfg_pkg::POLY_4 :
                                                     serial_link_cfg_pkg::POLY_3;
   wire [7:0] seed_dflt =
      (len_next == serial_link_cfg_pkg::LEN_SEL_8) ? serial_link_cfg_pkg::SEED_DEFAULT_8 :
      (len_next == serial_link_cfg_pkg::LEN_SEL_4) ? serial_link_cfg_pkg::SEED_DEFAULT_4 :
                                                     serial_link_cfg_pkg::SEED_DEFAULT_3;
   wire [7:0] seed_mask =
      (len_next == serial_link_cfg_pkg::LEN_SEL_8) ? serial_link_cfg_pkg::SEED_MASK_8 :
      (len_next == serial_link_cfg_pkg::LEN_SEL_4) ? serial_link_cfg_pkg::SEED_MASK_4 :
                                                     serial_link_cfg_pkg::SEED_MASK_3;
   wire [7:0] seed_next = seed_zero ? seed_dflt : (seed_wide & seed_mask);

   // active check settings move only at a command boundary
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         check_len_sel_reg <= serial_link_cfg_pkg::LEN_SEL_8;
         check_poly_reg    <= serial_link_cfg_pkg::POLY_8;
         check_seed_reg    <= serial_link_cfg_pkg::SEED_DEFAULT_8;
      end else if (cmd_event) begin
         check_len_sel_reg <= len_next;
         check_poly_reg    <= poly_next;
         check_seed_reg    <= seed_next;
      end
   end

   // ---------------------------------------------------------------
   // channel steering, field width and client address
   // ---------------------------------------------------------------
   wire [1:0] src_enable = {tag_1_val[serial_link_cfg_pkg::TAG_ENABLE_BIT],
                            tag_0_val[serial_link_cfg_pkg::TAG_ENABLE_BIT]};
   // spi mode picks result or error response, i2c mode uses wrap only
   wire [1:0] sel_next   = mode_i2c_sync ? 2'h0 : src_enable;
   wire [1:0] wrap_next  = mode_i2c_sync ? src_enable : 2'h0;
   wire [3:0] id_0_next  = mode_i2c_sync ? 4'h0 :
      tag_0_val[serial_link_cfg_pkg::TAG_ID_MSB:serial_link_cfg_pkg::TAG_ID_LSB];
   wire [3:0] id_1_next  = mode_i2c_sync ? 4'h0 :
      tag_1_val[serial_link_cfg_pkg::TAG_ID_MSB:serial_link_cfg_pkg::TAG_ID_LSB];
   wire [6:0] addr_next  = client_read[serial_link_cfg_pkg::CLIENT_MSB:0];

   // registered steering outputs
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         result_sel_reg     <= 2'h0;
         wrap_en_reg        <= 2'h0;
         source_tag_0_reg   <= 4'h0;
         source_tag_1_reg   <= 4'h0;
         field_width_16_reg <= 1'b0;
         client_addr_reg    <= serial_link_cfg_pkg::CLIENT_ADDR_DEFAULT[6:0];
      end else begin
         result_sel_reg     <= sel_next;
         wrap_en_reg        <= wrap_next;
         source_tag_0_reg   <= id_0_next;
         source_tag_1_reg   <= id_1_next;
         field_width_16_reg <= cfg_val[serial_link_cfg_pkg::WIDTH_SEL_BIT];
         client_addr_reg    <= addr_next;
      end
   end

endmodule // serial_link_config_regs

`default_nettype wire

/* logic/sync_two_ff.sv */
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ns
`default_nettype none

module sync_two_ff #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // data
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one_reg;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage_one_reg <= '0;
         sync_out      <= '0;
      end else begin
         stage_one_reg <= async_in;
         sync_out      <= stage_one_reg;
      end
   end

endmodule // sync_two_ff

`default_nettype wire

/* verification/serial_link_cfg_monitor.sv */
// assertion checker for the serial link configuration register bank
`timescale 1ns/1ns
`default_nettype none

module serial_link_cfg_monitor (
   // clocks and reset
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   input  wire logic       link_clk,
   // link access
   input  wire logic       link_req,
   input  wire logic       link_cmd_start,
   input  wire logic       link_done_reg,
   input  wire logic       link_busy_reg,
   // steering and check setup
   input  wire logic       i2c_mode,
   input  wire logic [1:0] result_sel_reg,
   input  wire logic [1:0] wrap_en_reg,
   input  wire logic [3:0] source_tag_0_reg,
   input  wire logic [3:0] source_tag_1_reg,
   input  wire logic [1:0] check_len_sel_reg,
   input  wire logic [7:0] check_poly_reg,
   input  wire logic [7:0] check_seed_reg
);
   logic [4:0] since_cmd;

   // sys cycles since a command start was last seen
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) since_cmd <= 5'h1F;
      else if (link_cmd_start) since_cmd <= 5'h00;
      else if (since_cmd != 5'h1F) since_cmd <= since_cmd + 5'h01;
   end

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   chk_len_code: assert property (@(posedge sys_clk) disable iff (!reset_n)
      check_len_sel_reg != 2'h3) else $error("check length code 3 active");
   chk_poly_match: assert property (@(posedge sys_clk) disable iff (!reset_n)
      check_poly_reg == ((check_len_sel_reg == 2'h0) ? 8'h2F :
      (check_len_sel_reg == 2'h1) ? 8'h01 : 8'h03)) else $error("polynomial off length");
   chk_seed_width: assert property (@(posedge sys_clk) disable iff (!reset_n)
      check_len_sel_reg != 2'h0 |-> check_seed_reg[7:4] == 4'h0 &&
      ((check_len_sel_reg == 2'h1) ? check_seed_reg != 8'h00 : !check_seed_reg[3]))
      else $error("seed too wide");
   chk_i2c_steer: assert property (@(posedge sys_clk) disable iff (!reset_n)
      i2c_mode [*4] |-> result_sel_reg == 2'h0 && source_tag_0_reg == 4'h0 &&
      source_tag_1_reg == 4'h0) else $error("steering in I2C mode");
   chk_spi_wrap: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (!i2c_mode) [*4] |-> wrap_en_reg == 2'h0) else $error("wrap-around in SPI mode");
   chk_cfg_on_cmd: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $changed(check_seed_reg) || $changed(check_poly_reg) || $changed(check_len_sel_reg)
      |-> since_cmd < 5'h10) else $error("setup moved without command");
   chk_req_accept: assert property (@(posedge link_clk) disable iff (!reset_n)
      link_req && !link_busy_reg |=> link_busy_reg) else $error("idle request not taken");
   chk_answer_bound: assert property (@(posedge link_clk) disable iff (!reset_n)
      $rose(link_busy_reg) |-> ##[1:7] link_done_reg) else $error("answer too late");
   chk_done_pulse: assert property (@(posedge link_clk) disable iff (!reset_n)
      link_done_reg |-> !link_busy_reg ##1 !link_done_reg) else $error("answer not a pulse");

   // main scenarios reached
   cov_answer: cover property (@(posedge link_clk) disable iff (!reset_n) link_done_reg);
   cov_setup: cover property (@(posedge sys_clk) disable iff (!reset_n)
      $changed(check_seed_reg));
   cov_wrap: cover property (@(posedge sys_clk) disable iff (!reset_n) wrap_en_reg != 2'h0);

endmodule // serial_link_cfg_monitor

bind serial_link_config_regs serial_link_cfg_monitor mon (
   .sys_clk, .reset_n, .link_clk, .link_req, .link_cmd_start, .link_done_reg,
   .link_busy_reg, .i2c_mode, .result_sel_reg, .wrap_en_reg, .source_tag_0_reg,
   .source_tag_1_reg, .check_len_sel_reg, .check_poly_reg, .check_seed_reg);

`default_nettype wire

/* verification/serial_link_host_model.sv */
// host model: link clock, register requests and command starts
`timescale 1ns/1ns
`default_nettype none

module serial_link_host_model (
   // link clock made by the host
   output var  logic       link_clk,
   // answers from the register bank
   input  wire logic       link_done_reg,
   input  wire logic [7:0] link_rdata_reg,
   // request and command lines
   output var  logic       link_req,
   output var  logic       link_wr,
   output var  logic [7:0] link_addr,
   output var  logic [7:0] link_wdata,
   output var  logic       link_cmd_start
);
   logic run;

   // idle lines, clock running through reset
   initial begin
      run = 1'b1;
      link_clk = 1'b0;
      {link_req, link_wr, link_addr, link_wdata, link_cmd_start} = 19'h0_0000;
   end

   // clock stands still between frames
   always #32 if (run) link_clk = ~link_clk;

   // one access, qualifiers held until the answer
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                         output logic [7:0] rdata);
      int n;
      run = 1'b1;
      @(posedge link_clk);
      link_req <= 1'b1;
      link_wr <= wr;
      link_addr <= addr;
      link_wdata <= wdata;
      @(posedge link_clk);
      link_req <= 1'b0;
      n = 0;
      do begin
         @(posedge link_clk);
         n++;
      end while (link_done_reg !== 1'b1 && n < 10);
      rdata = (link_done_reg === 1'b1) ? link_rdata_reg : 8'hxx;
      // released lines show the inverse
      link_wr <= ~wr;
      link_addr <= ~addr;
      link_wdata <= ~wdata;
      run = 1'b0;
   endtask

   // one command start, one link clock cycle long, no answer awaited
   task automatic command();
      run = 1'b1;
      @(posedge link_clk);
      link_cmd_start <= 1'b1;
      @(posedge link_clk);
      link_cmd_start <= 1'b0;
      @(posedge link_clk);
      run = 1'b0;
   endtask

endmodule // serial_link_host_model

`default_nettype wire

/* verification/tb_serial_link_config_regs.sv */
// self-checking bench for the serial link configuration register bank
`timescale 1ns/1ns
`default_nettype none

module tb_serial_link_config_regs;
   localparam logic [7:0]  IDENT = 8'h3C; // arbitrary identifier value
   localparam logic [15:0] RESET_MAP [6] = '{16'h1A00, 16'h1B00, 16'h3D00,
                                             {8'h3E, IDENT}, 16'h3F60, 16'h2000};
   localparam logic [31:0] RW_MAP [6] = '{32'h3E01_0160, {16'h3E00, IDENT, 8'h60},
      32'h205A_0060, 32'h3FA7_A727, 32'h3F80_8000, 32'h3F00_6060};
   localparam logic [31:0] STEER [2] = '{32'h850B_045B, 32'h058B_085B};
   localparam logic [7:0]  CFG_LIST [9] = '{8'h45, 8'h10, 8'h1C, 8'h20, 8'h2D, 8'h30,
                                            8'h7B, 8'h28, 8'h00};

   logic        sys_clk, reset_n, link_clk, link_req, link_wr, link_cmd_start;
   logic        link_done_reg, link_busy_reg, i2c_mode, field_width_16_reg, array_fault_reg;
   logic [1:0]  result_sel_reg, wrap_en_reg, check_len_sel_reg;
   logic [3:0]  source_tag_0_reg, source_tag_1_reg;
   logic [6:0]  client_addr_reg;
   logic [7:0]  link_addr, link_wdata, link_rdata_reg, check_poly_reg, check_seed_reg, rd;
   logic [23:0] prev;
   int          bad_count, samples_checked, cycles;
   wire  [23:0] setup_now = {6'h00, check_len_sel_reg, check_poly_reg, check_seed_reg};
   wire  [11:0] steer_now = {result_sel_reg, wrap_en_reg, source_tag_0_reg, source_tag_1_reg};

   serial_link_config_regs #(.PART_IDENT_CODE(IDENT)) dut (
      .sys_clk, .reset_n, .link_clk, .link_req, .link_wr, .link_addr, .link_wdata,
      .link_cmd_start, .link_rdata_reg, .link_done_reg, .link_busy_reg, .i2c_mode,
      .result_sel_reg, .wrap_en_reg, .source_tag_0_reg, .source_tag_1_reg,
      .field_width_16_reg, .check_len_sel_reg, .check_poly_reg, .check_seed_reg,
      .client_addr_reg, .array_fault_reg);

   serial_link_host_model host (
      .link_clk, .link_done_reg, .link_rdata_reg, .link_req, .link_wr, .link_addr,
      .link_wdata, .link_cmd_start);

   // ---------------------------------------------------------------
   // clock, hang guard, helpers
   // ---------------------------------------------------------------
   always #5 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         test_done();
      end
   end

   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         bad_count++;
      end
   endtask

   task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
      host.access(1'b0, addr, 8'h00, rd);
      check($sformatf("register %h", addr), {16'h0000, exp}, {16'h0000, rd});
   endtask

   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      host.access(1'b1, addr, data, rd);
   endtask

   // expected length, polynomial and seed for a configuration value
   function automatic logic [23:0] setup_of(input logic [7:0] c);
      logic [7:0] seed;
      if (c[5]) seed = (c[3:0] == 4'h0) ? 8'h07 : {5'h00, c[2:0]};
      else if (c[4]) seed = (c[3:0] == 4'h0) ? 8'h0A : {4'h0, c[3:0]};
      else seed = (c[3:0] == 4'h0) ? 8'hFF : {4'h0, c[3:0]};
      return {6'h00, c[5] ? 2'h2 : {1'b0, c[4]}, c[5] ? 8'h03 : c[4] ? 8'h01 : 8'h2F, seed};
   endfunction

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      {sys_clk, reset_n, i2c_mode} = 3'h0;
      {bad_count, samples_checked, cycles} = '0;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (20) @(posedge sys_clk);
      check("setup", setup_now, 24'h00_2FFF);
      check("client address", {17'h0_0000, client_addr_reg}, 24'h00_0060);
      for (int i = 0; i < 6; i++) begin
         reg_read(RESET_MAP[i][15:8], RESET_MAP[i][7:0]);
      end
      $display("test reset values done");
      for (int i = 0; i < 6; i++) begin
         reg_write(RW_MAP[i][31:24], RW_MAP[i][23:16]);
         reg_read(RW_MAP[i][31:24], RW_MAP[i][15:8]);
         check("client address", {17'h0_0000, client_addr_reg}, {16'h0000, RW_MAP[i][7:0]});
      end
      $display("test read back done");
      for (int i = 0; i < 2; i++) begin
         reg_write(8'h1A, STEER[i][31:24]);
         reg_write(8'h1B, STEER[i][23:16]);
         check("steering", {12'h000, steer_now}, {12'h000, STEER[i][11:0]});
      end
      @(posedge sys_clk);
      i2c_mode <= 1'b1;
      repeat (5) @(posedge sys_clk);
      check("steering", {12'h000, steer_now}, 24'h00_0200);
      reg_read(8'h1A, 8'h05);
      reg_read(8'h1B, 8'h8B);
      reg_read(8'h3F, 8'h60);
      reg_write(8'h3D, 8'h7B);
      reg_read(8'h3D, 8'h7B);
      @(posedge sys_clk);
      i2c_mode <= 1'b0;
      $display("test source steering done");
      prev = 24'h00_2FFF;
      for (int i = 0; i < 9; i++) begin
         reg_write(8'h3D, CFG_LIST[i]);
         repeat (3) @(posedge sys_clk);
         check("field width", {23'h00_0000, field_width_16_reg}, {23'h00_0000, CFG_LIST[i][6]});
         check("setup before command", setup_now, prev);
         host.command();
         repeat (8) @(posedge sys_clk);
         prev = setup_of(CFG_LIST[i]);
         check("setup", setup_now, prev);
      end
      check("array fault", {23'h00_0000, array_fault_reg}, 24'h00_0000);
      $display("test check setup done");
      test_done();
   end

endmodule // tb_serial_link_config_regs

`default_nettype wire
